/* hw/ttc_pkg.sv */
// Shared constants for the three-channel timer counter block.
package ttc_pkg;
    localparam int NUM_MODULES = 2;
    localparam int CH_PER_MODULE = 3;
    localparam int NUM_CH = 6;
    localparam int CNT_W = 32;
    localparam int PRESC_W = 7;
    localparam logic [31:0] CNT_MAX = 32'hffffffff;

    // Address layout: bit 8 picks the timer module, bits 7:6 the slot, bits 5:0 the offset.
    localparam logic [1:0] SLOT_BLOCK = 2'h3;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_MODE = 6'h04;
    localparam logic [5:0] OFF_CV = 6'h10;
    localparam logic [5:0] OFF_SR = 6'h20;
    localparam logic [5:0] OFF_MASK = 6'h2c;
    localparam logic [5:0] OFF_BCR = 6'h00;
    localparam logic [5:0] OFF_BMR = 6'h04;

    // Channel control register bits.
    localparam int CTRL_CLKEN_BIT = 0;
    localparam int CTRL_CLKDIS_BIT = 1;
    localparam int CTRL_SWTRG_BIT = 2;

    // Channel mode register fields.
    localparam int MODE_W = 8;
    localparam int MODE_CS_LSB = 0;
    localparam int MODE_WAVE_BIT = 3;
    localparam int MODE_DOWN_BIT = 4;
    localparam int MODE_GRAY_BIT = 5;
    localparam int MODE_TRG_LSB = 6;
    localparam logic [7:0] MODE_RST = 8'h00;

    // Status register bits.
    localparam int SR_OVF_BIT = 0;
    localparam int SR_CLKSTA_BIT = 16;
    localparam int SR_RUN_BIT = 17;

    // Block control and block mode.
    localparam int BCR_SYNC_BIT = 0;
    localparam int BMR_W = 6;
    localparam logic [5:0] BMR_RST = 6'h00;
    localparam logic [1:0] ROUTE_PIN = 2'h0;
    localparam logic [1:0] ROUTE_NEXT = 2'h1;
    localparam logic [1:0] ROUTE_PREV = 2'h2;

    // Clock select codes.
    localparam logic [2:0] CS_DIV2 = 3'h0;
    localparam logic [2:0] CS_DIV8 = 3'h1;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV128 = 3'h3;
    localparam logic [2:0] CS_SLOW = 3'h4;
    localparam logic [2:0] CS_XC0 = 3'h5;
    localparam logic [2:0] CS_XC1 = 3'h6;
    localparam logic [2:0] CS_XC2 = 3'h7;

    // Prescaler masks for the divided taps.
    localparam logic [6:0] DIV2_MASK = 7'h01;
    localparam logic [6:0] DIV8_MASK = 7'h07;
    localparam logic [6:0] DIV32_MASK = 7'h1f;
    localparam logic [6:0] DIV128_MASK = 7'h7f;

    // External trigger source codes.
    localparam logic [1:0] TRG_FIRST = 2'h1;
    localparam logic [1:0] TRG_SECOND = 2'h2;
endpackage

/* hw/ttc_top.sv */
// Two timer modules of three 32-bit channels each, with a classic Wishbone slave.
// Notes on behaviour
// - Three identical independent channels per module.
// - Six channels as two modules.
// - Counter and its paths are 32 bits.
// - Taps: divide by 2, 8, 32, 128, slow.
// - Three external clocks, two configurable lines.
// - Either line may trigger its channel.
// - First line input capture, output waveform.
// - Second line input, or output in waveform unless it is the trigger.
// - Each channel drives a maskable interrupt.
// - One interrupt line per timer module.
// - Block control write starts all three channels of its module.
// - Block mode routes external clocks for chaining.
// - Sync input comes from register write.
// - Up, down and 2-bit gray counting.
// - Source select zero makes slow tap every cycle.
// - Count on selected edge; wrap sets overflow.
// - Trigger clears counter at next selected edge.
// - Sync acts exactly like software trigger.
// - Mode field selects the counting clock.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ttc_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] ext_clock_pins_i,
    input wire logic slow_clock_i,
    input wire logic system_clock_source_select_i,
    input wire logic [5:0] channel_line_first_i,
    output logic [5:0] channel_line_first_o,
    output logic [5:0] channel_line_first_oe_o,
    input wire logic [5:0] channel_line_second_i,
    output logic [5:0] channel_line_second_o,
    output logic [5:0] channel_line_second_oe_o,
    output logic [5:0] channel_irq_o,
    output logic [1:0] module_irq_o
);

    function automatic logic tap_hit(input logic [6:0] cnt, input logic [6:0] mask);
        tap_hit = ((cnt & mask) == mask);
    endfunction

    function automatic logic [1:0] gray2(input logic [1:0] b);
        gray2 = {b[1], b[1] ^ b[0]};
    endfunction

    // Synchroniser stages; stage three only serves edge detection.
    logic [5:0] ext_s1_r, ext_s2_r;
    logic [5:0] first_s1_r, first_s2_r, first_s3_r;
    logic [5:0] second_s1_r, second_s2_r, second_s3_r;
    logic slow_s1_r, slow_s2_r, slow_s3_r;
    logic [6:0] presc_r;

    logic [31:0] cnt_r [ttc_pkg::NUM_CH];
    logic [7:0] mode_r [ttc_pkg::NUM_CH];
    logic [5:0] bmr_r [ttc_pkg::NUM_MODULES];
    logic [5:0] clk_en_r, run_r, pend_r, ovf_r, mask_r, tog_r, xc_prev_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [5:0] first_o_r, first_oe_r, second_o_r, second_oe_r, irq_r;
    logic [1:0] mod_irq_r;

    logic [5:0] xc_lvl, xc_rise, sel_tick, cnt_tick, trig_evt, ovf_evt;
    logic [5:0] ctrl_wr, mode_wr, mask_wr, sr_rd;
    logic [1:0] bcr_wr, bmr_wr;
    logic slow_tick, hit_ok, acc, wr_now, rd_now;
    logic [31:0] rd_data;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_s1_r <= 6'h00;
            ext_s2_r <= 6'h00;
            first_s1_r <= 6'h00;
            first_s2_r <= 6'h00;
            first_s3_r <= 6'h00;
            second_s1_r <= 6'h00;
            second_s2_r <= 6'h00;
            second_s3_r <= 6'h00;
            slow_s1_r <= 1'b0;
            slow_s2_r <= 1'b0;
            slow_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= ext_clock_pins_i;
            ext_s2_r <= ext_s1_r;
            first_s1_r <= channel_line_first_i;
            first_s2_r <= first_s1_r;
            first_s3_r <= first_s2_r;
            second_s1_r <= channel_line_second_i;
            second_s2_r <= second_s1_r;
            second_s3_r <= second_s2_r;
            slow_s1_r <= slow_clock_i;
            slow_s2_r <= slow_s1_r;
            slow_s3_r <= slow_s2_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            presc_r <= 7'h00;
        else
            presc_r <= presc_r + 7'h01;
    end

    assign slow_tick = system_clock_source_select_i ? (slow_s2_r & ~slow_s3_r) : 1'b1;

    // The routed clocks are levels; their edges are found against last cycle's level.
    // one routed clock per channel, three per module
    always_comb
    begin
        for (int c = 0; c < ttc_pkg::NUM_CH; c++)
        begin
            int m;
            int k;
            logic [1:0] route;
            m = c / ttc_pkg::CH_PER_MODULE;
            k = c % ttc_pkg::CH_PER_MODULE;
            route = bmr_r[m][2*k +: 2];
            unique case (route)
                ttc_pkg::ROUTE_PIN: xc_lvl[c] = ext_s2_r[c];
                ttc_pkg::ROUTE_NEXT: xc_lvl[c] = first_o_r[m*3 + (k+1)%3];
                ttc_pkg::ROUTE_PREV: xc_lvl[c] = first_o_r[m*3 + (k+2)%3];
                default: xc_lvl[c] = 1'b0;
            endcase
        end
        xc_rise = xc_lvl & ~xc_prev_r;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            xc_prev_r <= 6'h00;
        else
            xc_prev_r <= xc_lvl;
    end

    // Bus decode; writes land on the edge at which the master samples ack.
    always_comb
    begin
        hit_ok = (wb_adr_i[31:9] == 23'h000000) && (wb_adr_i[1:0] == 2'h0);
        acc = wb_cyc_i & wb_stb_i;
        wr_now = ack_r & acc & wb_we_i & wb_sel_i[0] & hit_ok;
        rd_now = ack_r & acc & ~wb_we_i & hit_ok;
        for (int c = 0; c < ttc_pkg::NUM_CH; c++)
        begin
            logic hit;
            hit = (wb_adr_i[7:6] != ttc_pkg::SLOT_BLOCK)
                && ((int'(wb_adr_i[8]) * 3 + int'(wb_adr_i[7:6])) == c);
            ctrl_wr[c] = wr_now && hit && (wb_adr_i[5:0] == ttc_pkg::OFF_CTRL);
            mode_wr[c] = wr_now && hit && (wb_adr_i[5:0] == ttc_pkg::OFF_MODE);
            mask_wr[c] = wr_now && hit && (wb_adr_i[5:0] == ttc_pkg::OFF_MASK);
            sr_rd[c] = rd_now && hit && (wb_adr_i[5:0] == ttc_pkg::OFF_SR);
        end
        for (int m = 0; m < ttc_pkg::NUM_MODULES; m++)
        begin
            logic bhit;
            bhit = (wb_adr_i[7:6] == ttc_pkg::SLOT_BLOCK) && (int'(wb_adr_i[8]) == m);
            bcr_wr[m] = wr_now && bhit && (wb_adr_i[5:0] == ttc_pkg::OFF_BCR);
            bmr_wr[m] = wr_now && bhit && (wb_adr_i[5:0] == ttc_pkg::OFF_BMR);
        end
    end

    // Per-channel clock choice, triggers and counting events.
    always_comb
    begin
        for (int c = 0; c < ttc_pkg::NUM_CH; c++)
        begin
            int m;
            logic wave;
            logic down;
            logic [1:0] trg;
            m = c / ttc_pkg::CH_PER_MODULE;
            wave = mode_r[c][ttc_pkg::MODE_WAVE_BIT];
            down = mode_r[c][ttc_pkg::MODE_DOWN_BIT];
            trg = mode_r[c][ttc_pkg::MODE_TRG_LSB +: 2];
            unique case (mode_r[c][ttc_pkg::MODE_CS_LSB +: 3])
                ttc_pkg::CS_DIV2: sel_tick[c] = tap_hit(presc_r, ttc_pkg::DIV2_MASK);
                ttc_pkg::CS_DIV8: sel_tick[c] = tap_hit(presc_r, ttc_pkg::DIV8_MASK);
                ttc_pkg::CS_DIV32: sel_tick[c] = tap_hit(presc_r, ttc_pkg::DIV32_MASK);
                ttc_pkg::CS_DIV128: sel_tick[c] = tap_hit(presc_r, ttc_pkg::DIV128_MASK);
                ttc_pkg::CS_SLOW: sel_tick[c] = slow_tick;
                ttc_pkg::CS_XC0: sel_tick[c] = xc_rise[m*3];
                ttc_pkg::CS_XC1: sel_tick[c] = xc_rise[m*3 + 1];
                ttc_pkg::CS_XC2: sel_tick[c] = xc_rise[m*3 + 2];
            endcase
            // either line as trigger, sync from block write
            // sync joins the software trigger, one write hits all three.
            trig_evt[c] = (ctrl_wr[c] & wb_dat_i[ttc_pkg::CTRL_SWTRG_BIT])
                | (bcr_wr[m] & wb_dat_i[ttc_pkg::BCR_SYNC_BIT])
                | ((trg == ttc_pkg::TRG_FIRST) & ~wave & first_s2_r[c] & ~first_s3_r[c])
                | ((trg == ttc_pkg::TRG_SECOND) & second_s2_r[c] & ~second_s3_r[c]);
            cnt_tick[c] = sel_tick[c] & clk_en_r[c] & run_r[c] & ~pend_r[c];
            ovf_evt[c] = cnt_tick[c] & (down ? (cnt_r[c] == 32'h00000000)
                : (cnt_r[c] == ttc_pkg::CNT_MAX));
        end
    end

    // every channel runs the same logic
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int c = 0; c < ttc_pkg::NUM_CH; c++)
            begin
                cnt_r[c] <= 32'h00000000;
            end
            clk_en_r <= 6'h00;
            run_r <= 6'h00;
            pend_r <= 6'h00;
        end
        else
        begin
            for (int c = 0; c < ttc_pkg::NUM_CH; c++)
            begin
                // Disable wins over enable when both are written together.
                if (ctrl_wr[c] && wb_dat_i[ttc_pkg::CTRL_CLKDIS_BIT])
                    clk_en_r[c] <= 1'b0;
                else if (ctrl_wr[c] && wb_dat_i[ttc_pkg::CTRL_CLKEN_BIT])
                    clk_en_r[c] <= 1'b1;
                // trigger waits for the selected edge
                if (pend_r[c] && sel_tick[c])
                    pend_r[c] <= trig_evt[c];
                else if (trig_evt[c])
                    pend_r[c] <= 1'b1;
                if (!clk_en_r[c])
                    run_r[c] <= 1'b0;
                else if (pend_r[c] && sel_tick[c])
                    run_r[c] <= 1'b1;
                if (pend_r[c] && sel_tick[c])
                    cnt_r[c] <= 32'h00000000;
                else if (cnt_tick[c])
                    cnt_r[c] <= mode_r[c][ttc_pkg::MODE_DOWN_BIT]
                        ? cnt_r[c] - 32'h00000001 : cnt_r[c] + 32'h00000001;
            end
        end
    end

    // Configuration registers; only byte lane 0 carries writable fields.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int c = 0; c < ttc_pkg::NUM_CH; c++)
            begin
                mode_r[c] <= ttc_pkg::MODE_RST;
            end
            for (int m = 0; m < ttc_pkg::NUM_MODULES; m++)
            begin
                bmr_r[m] <= ttc_pkg::BMR_RST;
            end
            mask_r <= 6'h00;
        end
        else
        begin
            for (int c = 0; c < ttc_pkg::NUM_CH; c++)
            begin
                if (mode_wr[c])
                    mode_r[c] <= wb_dat_i[ttc_pkg::MODE_W-1:0];
                if (mask_wr[c])
                    mask_r[c] <= wb_dat_i[ttc_pkg::SR_OVF_BIT];
            end
            for (int m = 0; m < ttc_pkg::NUM_MODULES; m++)
            begin
                if (bmr_wr[m])
                    bmr_r[m] <= wb_dat_i[ttc_pkg::BMR_W-1:0];
            end
        end
    end

    // Overflow is sticky and clears on status read; a new wrap beats the clear.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ovf_r <= 6'h00;
        else
            ovf_r <= ovf_evt | (ovf_r & ~sr_rd);
    end

    // Waveform lines; one cycle behind the counter, which is half the divide-by-2 tap period.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tog_r <= 6'h00;
            first_o_r <= 6'h00;
            first_oe_r <= 6'h00;
            second_o_r <= 6'h00;
            second_oe_r <= 6'h00;
        end
        else
        begin
            tog_r <= tog_r ^ ovf_evt;
            for (int c = 0; c < ttc_pkg::NUM_CH; c++)
            begin
                logic gray;
                logic wave;
                logic [1:0] ph;
                gray = mode_r[c][ttc_pkg::MODE_GRAY_BIT];
                wave = mode_r[c][ttc_pkg::MODE_WAVE_BIT];
                ph = gray2(cnt_r[c][1:0]);
                first_o_r[c] <= gray ? ph[0] : tog_r[c];
                second_o_r[c] <= gray ? ph[1] : cnt_r[c][ttc_pkg::CNT_W-1];
                // first line drives only in waveform
                first_oe_r[c] <= wave;
                // second line yields when it is the trigger
                second_oe_r[c] <= wave
                    && (mode_r[c][ttc_pkg::MODE_TRG_LSB +: 2] != ttc_pkg::TRG_SECOND);
            end
        end
    end

    // channel interrupt, one line per module
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_r <= 6'h00;
            mod_irq_r <= 2'h0;
        end
        else
        begin
            irq_r <= ovf_r & mask_r;
            mod_irq_r <= {|(ovf_r[5:3] & mask_r[5:3]), |(ovf_r[2:0] & mask_r[2:0])};
        end
    end

    // Read multiplexer; unmapped addresses read zero and still acknowledge.
    always_comb
    begin
        int c;
        int m;
        rd_data = 32'h00000000;
        c = int'(wb_adr_i[8]) * 3 + int'(wb_adr_i[7:6]);
        m = int'(wb_adr_i[8]);
        if (hit_ok && wb_adr_i[7:6] != ttc_pkg::SLOT_BLOCK)
        begin
            unique case (wb_adr_i[5:0])
                ttc_pkg::OFF_MODE: rd_data[ttc_pkg::MODE_W-1:0] = mode_r[c];
                ttc_pkg::OFF_CV: rd_data = cnt_r[c];
                ttc_pkg::OFF_MASK: rd_data[ttc_pkg::SR_OVF_BIT] = mask_r[c];
                ttc_pkg::OFF_SR:
                begin
                    rd_data[ttc_pkg::SR_OVF_BIT] = ovf_r[c];
                    rd_data[ttc_pkg::SR_CLKSTA_BIT] = clk_en_r[c];
                    rd_data[ttc_pkg::SR_RUN_BIT] = run_r[c];
                end
                default: rd_data = 32'h00000000;
            endcase
        end
        else if (hit_ok && wb_adr_i[5:0] == ttc_pkg::OFF_BMR)
            rd_data[ttc_pkg::BMR_W-1:0] = bmr_r[m];
    end

    // Ack one cycle after the request, dropped the cycle after it is given.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= acc & ~ack_r;
            if (acc && !ack_r && !wb_we_i)
                dat_r <= rd_data;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign channel_line_first_o = first_o_r;
    assign channel_line_first_oe_o = first_oe_r;
    assign channel_line_second_o = second_o_r;
    assign channel_line_second_oe_o = second_oe_r;
    assign channel_irq_o = irq_r;
    assign module_irq_o = mod_irq_r;

endmodule

`default_nettype wire

/* test/ttc_properties.sv */
// Port checker for the timer block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module ttc_properties (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [5:0] channel_line_first_oe_o,
    input wire logic [5:0] channel_line_second_oe_o,
    input wire logic [5:0] channel_irq_o,
    input wire logic [1:0] module_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_hold;
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_mod0_irq;
        module_irq_o[0] == (|channel_irq_o[2:0]);
    endproperty
    a_mod0_irq: assert property (p_mod0_irq) else $error("module 0 irq wrong");
    property p_mod1_irq;
        (|channel_irq_o[5:3]) |-> module_irq_o[1] ##1 (module_irq_o[1] == (|channel_irq_o[5:3]));
    endproperty
    a_mod1_irq: assert property (p_mod1_irq) else $error("module 1 irq wrong");
    property p_oe_pair;
        (channel_line_second_oe_o & ~channel_line_first_oe_o) == 6'h00;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("second line driven in capture");
    property p_oe_cause;
        $changed({channel_line_first_oe_o, channel_line_second_oe_o})
            |-> $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("line direction moved alone");
endmodule
bind ttc_top ttc_properties u_props (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .channel_line_first_oe_o(channel_line_first_oe_o),
    .channel_line_second_oe_o(channel_line_second_oe_o),
    .channel_irq_o(channel_irq_o),
    .module_irq_o(module_irq_o)
);
`default_nettype wire

/* test/ttc_far_end.sv */
// Far-side model: external clock pins, slow clock and channel lines.
`timescale 1ns/1ns
`default_nettype none
module ttc_far_end (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic burst_go_i,
    input wire logic [7:0] burst_len_i,
    input wire logic [5:0] first_drive_i,
    input wire logic [5:0] first_out_i,
    input wire logic [5:0] first_oe_i,
    input wire logic [5:0] second_out_i,
    input wire logic [5:0] second_oe_i,
    output logic [5:0] ext_clock_pins_o,
    output logic slow_clock_o,
    output logic [5:0] first_line_o,
    output logic [5:0] second_line_o
);
    logic [7:0] left_r;
    logic [2:0] phase_r;
    logic [3:0] slow_r;
    logic pin_clk;
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left_r <= 8'h00;
            phase_r <= 3'h0;
        end
        else if (burst_go_i)
        begin
            left_r <= burst_len_i;
            phase_r <= 3'h0;
        end
        else if (left_r != 8'h00)
        begin
            phase_r <= phase_r + 3'h1;
            if (phase_r == 3'h7)
                left_r <= left_r - 8'h01;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            slow_r <= 4'h0;
        else
            slow_r <= slow_r + 4'h1;
    end
    // Levels last four cycles so the block can always see them; idle pins stand low.
    assign pin_clk = (left_r != 8'h00) && phase_r[2];
    assign ext_clock_pins_o = {2'h0, pin_clk, 2'h0, pin_clk};
    assign slow_clock_o = slow_r[3];
    assign first_line_o = (first_oe_i & first_out_i) | (~first_oe_i & first_drive_i);
    assign second_line_o = (second_oe_i & second_out_i) | (~second_oe_i & {6{slow_r[2]}});
endmodule
`default_nettype wire

/* test/three_channel_timer_counter_test.sv */
// Self-checking bench for the two-module timer block.
`timescale 1ns/1ns
`default_nettype none
module three_channel_timer_counter_test;
    logic sys_clk_i;
    logic rst_n_i = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic system_clock_source_select = 1'h1;
    logic go = 1'h0;
    logic [5:0] f_drive = 6'h0;
    logic [5:0] ext_pins, f_in, f_out, f_oe, s_in, s_out, s_oe, ch_irq;
    logic slow;
    logic [1:0] m_irq;
    logic [31:0] v, w;
    int cyc = 0;
    int t_samp, t1;
    int checks = 0;
    int n_mismatch = 0;
    int dv[6] = '{2, 8, 32, 128, 1, 16};
    ttc_top DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_clock_pins_i(ext_pins), .slow_clock_i(slow), .system_clock_source_select_i(system_clock_source_select),
        .channel_line_first_i(f_in), .channel_line_first_o(f_out),
        .channel_line_first_oe_o(f_oe), .channel_line_second_i(s_in),
        .channel_line_second_o(s_out), .channel_line_second_oe_o(s_oe),
        .channel_irq_o(ch_irq), .module_irq_o(m_irq));
    ttc_far_end u_far (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .burst_go_i(go),
        .burst_len_i(8'h0a), .first_drive_i(f_drive), .first_out_i(f_out), .first_oe_i(f_oe),
        .second_out_i(s_out), .second_oe_i(s_oe), .ext_clock_pins_o(ext_pins),
        .slow_clock_o(slow), .first_line_o(f_in), .second_line_o(s_in));
    initial
    begin
        sys_clk_i = 1'h0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (wb_ack_o !== 1'h1 && k < 40);
        if (wb_ack_o !== 1'h1)
            n_mismatch++;
        t_samp = cyc;
        r = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'h1, a, d, r);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'h0, a, 32'h0, r);
        check(what, r, exp);
    endtask
    function automatic logic [31:0] ma(input int ch, input logic [5:0] off);
        return {23'h0, 1'(ch / 3), 2'(ch % 3), off};
    endfunction
    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'hc87f32bc));
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        for (int c = 0; c < 6; c++)
        begin
            rd_chk("mode", ma(c, ttc_pkg::OFF_MODE), 32'h0);
            rd_chk("status", ma(c, ttc_pkg::OFF_SR), 32'h0);
            v = $urandom() & 32'hff;
            wr(ma(c, ttc_pkg::OFF_MODE), v);
            rd_chk("mode back", ma(c, ttc_pkg::OFF_MODE), v);
            check("oe first", f_oe[c], v[3]);
            check("oe second", s_oe[c], v[3] && v[7:6] != 2'h2);
        end
        rd_chk("unmapped", 32'h208, 32'h0);
        rd_chk("bmr", {24'h0, ttc_pkg::SLOT_BLOCK, ttc_pkg::OFF_BMR}, 32'h0);
        v = $urandom() & 32'h3f;
        wr({24'h0, ttc_pkg::SLOT_BLOCK, ttc_pkg::OFF_BMR}, v);
        rd_chk("bmr back", {24'h0, ttc_pkg::SLOT_BLOCK, ttc_pkg::OFF_BMR}, v);
        wr({24'h0, ttc_pkg::SLOT_BLOCK, ttc_pkg::OFF_BMR}, 32'h0);
        for (int c = 0; c < 6; c++)
        begin
            @(posedge sys_clk_i);
            system_clock_source_select <= (c != 4);
            wr(ma(c, ttc_pkg::OFF_MODE), (c < 4) ? c : 4);
            wr(ma(c, ttc_pkg::OFF_CTRL), 32'h5);
            repeat (300) @(negedge sys_clk_i);
            wb(1'h0, ma(c, ttc_pkg::OFF_CV), 32'h0, v);
            t1 = t_samp;
            while (cyc < t1 + 1022) @(negedge sys_clk_i);
            wb(1'h0, ma(c, ttc_pkg::OFF_CV), 32'h0, w);
            check("tap ticks", w - v, (t_samp - t1) / dv[c]);
        end
        for (int c = 0; c < 3; c++)
        begin
            wr(ma(c, ttc_pkg::OFF_CTRL), 32'h2);
            wr(ma(c, ttc_pkg::OFF_CTRL), 32'h1);
            rd_chk("idle", ma(c, ttc_pkg::OFF_SR), 32'h10000);
        end
        wr({24'h0, ttc_pkg::SLOT_BLOCK, ttc_pkg::OFF_BCR}, 32'h1);
        repeat (300) @(negedge sys_clk_i);
        for (int c = 0; c < 3; c++)
            rd_chk("synced", ma(c, ttc_pkg::OFF_SR), 32'h30000);
        wr(ma(3, ttc_pkg::OFF_MODE), 32'h10);
        wr(ma(3, ttc_pkg::OFF_MASK), 32'h1);
        wr(ma(3, ttc_pkg::OFF_CTRL), 32'h5);
        repeat (20) @(negedge sys_clk_i);
        check("chan irq", ch_irq, 6'h08);
        check("module irq", m_irq, 2'h2);
        check("wave lines", {f_out[3], s_out[3]}, 2'h3);
        wb(1'h0, ma(3, ttc_pkg::OFF_CV), 32'h0, v);
        check("down count", v[31:8], 24'hffffff);
        rd_chk("ovf set", ma(3, ttc_pkg::OFF_SR), 32'h30001);
        rd_chk("ovf clear", ma(3, ttc_pkg::OFF_SR), 32'h30000);
        repeat (3) @(negedge sys_clk_i);
        check("irq low", {m_irq, ch_irq}, 8'h00);
        wr(ma(1, ttc_pkg::OFF_MODE), 32'h45);
        wr(ma(1, ttc_pkg::OFF_CTRL), 32'h2);
        wr(ma(1, ttc_pkg::OFF_CTRL), 32'h1);
        @(posedge sys_clk_i);
        f_drive <= 6'h02;
        @(posedge sys_clk_i);
        go <= 1'h1;
        @(posedge sys_clk_i);
        go <= 1'h0;
        repeat (120) @(negedge sys_clk_i);
        rd_chk("ext count", ma(1, ttc_pkg::OFF_CV), 32'h9);
        rd_chk("line start", ma(1, ttc_pkg::OFF_SR), 32'h30000);
        wr(ma(2, ttc_pkg::OFF_MODE), 32'h80);
        wr(ma(2, ttc_pkg::OFF_CTRL), 32'h2);
        wr(ma(2, ttc_pkg::OFF_CTRL), 32'h1);
        repeat (60) @(negedge sys_clk_i);
        rd_chk("second start", ma(2, ttc_pkg::OFF_SR), 32'h30000);
        report_and_stop();
    end
endmodule
`default_nettype wire
